//--- logic/dpsm_consts.vh
// constants for the dds parameter source multiplexer
`ifndef DPSM_CONSTS_VH
`define DPSM_CONSTS_VH
// widths of the synthesizer control words
`define DPSM_FREQ_W 32
`define DPSM_PHASE_W 16
`define DPSM_AMP_W 14
// waveform memory geometry
`define DPSM_RAM_DEPTH 1024
`define DPSM_RAM_AW 10
`define DPSM_RAM_DW 32
// parallel port layout
`define DPSM_PORT_W 18
`define DPSM_PORT_DATA_LSB 2
// destination codes of the parallel port
`define DPSM_DEST_AMP 2'h0
`define DPSM_DEST_PHASE 2'h1
`define DPSM_DEST_FREQ 2'h2
`define DPSM_DEST_POLAR 2'h3
// ram profile destinations
`define DPSM_RDEST_FREQ 2'h0
`define DPSM_RDEST_PHASE 2'h1
`define DPSM_RDEST_AMP 2'h2
`define DPSM_RDEST_POLAR 2'h3
// update clock and port data clock dividers (in ref_clk cycles)
`define DPSM_UPD_DIV 4
`define DPSM_PORT_DATA_CLOCK_DIV 4
// register map (word byte addresses)
`define DPSM_A_CTRL 8'h00
`define DPSM_A_FTW 8'h04
`define DPSM_A_POW_ASF 8'h08
`define DPSM_A_RAMP_UP 8'h0C
`define DPSM_A_RAMP_LO 8'h10
`define DPSM_A_RAMP_RSTEP 8'h14
`define DPSM_A_RAMP_FSTEP 8'h18
`define DPSM_A_RAMP_RATE 8'h1C
`define DPSM_A_RAM_ADDR 8'h20
`define DPSM_A_RAM_DATA 8'h24
`define DPSM_A_OSK 8'h28
`define DPSM_A_STATUS 8'h2C
`define DPSM_A_OUT_FREQ 8'h30
`define DPSM_A_PROF_FTW 8'h40
`define DPSM_A_PROF_PA 8'h60
`define DPSM_A_RPROF 8'h80
// control register fields
`define DPSM_C_RAM_EN 0
`define DPSM_C_RAMP_EN 1
`define DPSM_C_PORT_EN 2
`define DPSM_C_OSK_EN 3
`define DPSM_C_UPDATE 4
`define DPSM_C_RDEST_LSB 5
`define DPSM_C_FMGAIN_LSB 8
`define DPSM_C_HOLD_LAST 12
`define DPSM_CTRL_RST 32'h0000_0000
`endif

//--- logic/dpsm_ramp_gen.v
// 32-bit linear ramp generator with direction and hold inputs
`timescale 1ns/1ns
`include "dpsm_consts.vh"
module dpsm_ramp_gen (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire enable_i,
    input wire tick_i,
    input wire dir_up_i,
    input wire hold_i,
    input wire [31:0] upper_i,
    input wire [31:0] lower_i,
    input wire [31:0] rise_step_i,
    input wire [31:0] fall_step_i,
    input wire [15:0] rise_rate_i,
    input wire [15:0] fall_rate_i,
    output reg [31:0] acc_o,
    output reg at_limit_o
);
    reg [15:0] rate_cnt_reg; // cycles of tick left until the next step
    wire [32:0] up_sum = {1'b0, acc_o} + {1'b0, rise_step_i};
    wire [32:0] dn_dif = {1'b0, acc_o} - {1'b0, fall_step_i};

    // step on the rate counter, clamp at the limits, freeze on hold
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o <= 32'h0000_0000;
            at_limit_o <= 1'b0;
            rate_cnt_reg <= 16'h0000;
        end else if (!enable_i) begin
            // idle ramp parks at the lower limit so it starts cleanly
            acc_o <= lower_i;
            at_limit_o <= 1'b0;
            rate_cnt_reg <= 16'h0000;
        end else if (tick_i && !hold_i) begin
            if (rate_cnt_reg != 16'h0000) begin
                rate_cnt_reg <= rate_cnt_reg - 16'h0001;
            end else if (dir_up_i) begin
                rate_cnt_reg <= rise_rate_i;
                // saturate at the upper limit, overflow included
                if (up_sum[32] || up_sum[31:0] >= {1'b0, upper_i}) begin
                    acc_o <= upper_i;
                    at_limit_o <= 1'b1;
                end else begin
                    acc_o <= up_sum[31:0];
                    at_limit_o <= 1'b0;
                end
            end else begin
                rate_cnt_reg <= fall_rate_i;
                if (dn_dif[32] || dn_dif[31:0] <= lower_i) begin
                    acc_o <= lower_i;
                    at_limit_o <= 1'b1;
                end else begin
                    acc_o <= dn_dif[31:0];
                    at_limit_o <= 1'b0;
                end
            end
        end
    end
endmodule

//--- logic/dpsm_source_mux.v
// parameter source multiplexer: profiles, waveform ram, ramp, port, keying
// What this block does
// - four sources: tone, ram, ramp, port
// - tone takes eight pin-selected profile registers
// - profile change applies on next update tick
// - ram mode starts on enable plus update/profile
// - memory is 1024 words of 32 bits
// - timer paces ram reads into samples
// - eight ram profiles pick ram destination
// - polar splits sample into phase and magnitude
// - ramp limits, rise/fall step and rate
// - ramp gives freq 32, phase 16, amp 14
// - direction pin sets ramp slope
// - hold pin freezes ramp
// - port: 16-bit data above 2-bit destination
// - port data is unsigned binary
// - frequency destination adds offset to tuning word
// - gain field left-shifts data word
// - keying ramp overrides all amplitude sources
// - unmodulated parameters come from registers
// - several modes at once, fixed priority
// - port clock at quarter rate latches port
// - gate qualifies port words
// - limit flag high at ramp limits
// - ram beats port on frequency
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "dpsm_consts.vh"
module dpsm_source_mux #(
    parameter RAM_AW = `DPSM_RAM_AW,
    parameter UPD_DIV = `DPSM_UPD_DIV
) (
    input wire ref_clk_i,
    input wire nrst_i,
    // avalon-mm slave
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // pins from the host
    input wire [2:0] profile_i,
    input wire ramp_direction_pin_i,
    input wire ramp_hold_pin_i,
    input wire [17:0] port_data_i,
    input wire port_data_gate_i,
    // results
    output reg port_data_clock_o,
    output reg ramp_limit_flag_o,
    output reg [31:0] freq_o,
    output reg [15:0] phase_o,
    output reg [13:0] amp_o
);
    // reset release through two flops
    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // pin synchronisers, the first stage feeds only the second
    reg [2:0] prof_s1_reg, prof_s2_reg;
    reg dir_s1_reg, dir_s2_reg, hold_s1_reg, hold_s2_reg;
    reg gate_s1_reg, gate_s2_reg;
    reg [17:0] pd_s1_reg, pd_s2_reg;
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prof_s1_reg <= 3'h0;
            prof_s2_reg <= 3'h0;
            dir_s1_reg <= 1'b0;
            dir_s2_reg <= 1'b0;
            hold_s1_reg <= 1'b0;
            hold_s2_reg <= 1'b0;
            gate_s1_reg <= 1'b0;
            gate_s2_reg <= 1'b0;
            pd_s1_reg <= 18'h00000;
            pd_s2_reg <= 18'h00000;
        end else begin
            prof_s1_reg <= profile_i;
            prof_s2_reg <= prof_s1_reg;
            dir_s1_reg <= ramp_direction_pin_i;
            dir_s2_reg <= dir_s1_reg;
            hold_s1_reg <= ramp_hold_pin_i;
            hold_s2_reg <= hold_s1_reg;
            gate_s1_reg <= port_data_gate_i;
            gate_s2_reg <= gate_s1_reg;
            pd_s1_reg <= port_data_i;
            pd_s2_reg <= pd_s1_reg;
        end
    end

    // update clock divider: one-cycle tick every UPD_DIV cycles
    reg [7:0] upd_cnt_reg;
    wire upd_tick = (upd_cnt_reg == 8'h00);
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            upd_cnt_reg <= 8'h00;
        end else if (upd_tick) begin
            upd_cnt_reg <= UPD_DIV[7:0] - 8'h01;
        end else begin
            upd_cnt_reg <= upd_cnt_reg - 8'h01;
        end
    end

    // port clock: quarter rate square wave, rising edge carries the latch
    reg [1:0] pdc_cnt_reg;
    wire pdc_rise = (pdc_cnt_reg == 2'h1);
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pdc_cnt_reg <= 2'h0;
            port_data_clock_o <= 1'b0;
        end else begin
            pdc_cnt_reg <= pdc_cnt_reg + 2'h1;
            port_data_clock_o <= pdc_cnt_reg[1] ^ pdc_cnt_reg[0] ? 1'b1 : 1'b0;
        end
    end

    // software registers
    reg [31:0] ctrl_reg, ftw_reg, pow_asf_reg;
    reg [31:0] rup_reg, rlo_reg, rrs_reg, rfs_reg, rrate_reg, osk_reg;
    reg [RAM_AW-1:0] ram_waddr_reg;
    reg [31:0] prof_ftw_reg [0:7]; // per-profile tuning word
    reg [31:0] prof_pa_reg [0:7]; // per-profile phase and amplitude
    reg [31:0] rprof_reg [0:7]; // ram profile: dest, start, end, rate
    reg rd_pend_reg;
    reg [2:0] act_prof_reg; // profile in force since the last update tick
    reg prof_chg_reg; // profile moved at the last tick, kept until the next
    reg ram_active_reg; // ram playback running
    wire osk_en = ctrl_reg[`DPSM_C_OSK_EN];
    wire [31:0] wr_d = avs_writedata_i;
    wire [3:0] wr_be = avs_byteenable_i;
    wire ram_we = avs_write_i && (avs_address_i == `DPSM_A_RAM_DATA);
    integer k;

    // byte lane merge for writes
    function [31:0] dpsm_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer b;
        begin
            dpsm_merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    dpsm_merge[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
        end
    endfunction

    // writes take effect immediately; update bit is self clearing
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `DPSM_CTRL_RST;
            ftw_reg <= 32'h0000_0000;
            pow_asf_reg <= 32'h0000_0000;
            rup_reg <= 32'hFFFF_FFFF;
            rlo_reg <= 32'h0000_0000;
            rrs_reg <= 32'h0000_0000;
            rfs_reg <= 32'h0000_0000;
            rrate_reg <= 32'h0000_0000;
            osk_reg <= 32'h0000_0000;
            ram_waddr_reg <= {RAM_AW{1'b0}};
            for (k = 0; k < 8; k = k + 1) begin
                prof_ftw_reg[k] <= 32'h0000_0000;
                prof_pa_reg[k] <= 32'h0000_0000;
                rprof_reg[k] <= 32'h0000_0000;
            end
        end else begin
            if (upd_tick) begin
                ctrl_reg[`DPSM_C_UPDATE] <= 1'b0;
            end
            if (avs_write_i) begin
                case (avs_address_i)
                `DPSM_A_CTRL: ctrl_reg <= dpsm_merge(ctrl_reg, wr_d, wr_be);
                `DPSM_A_FTW: ftw_reg <= dpsm_merge(ftw_reg, wr_d, wr_be);
                `DPSM_A_POW_ASF: pow_asf_reg <= dpsm_merge(pow_asf_reg, wr_d, wr_be);
                `DPSM_A_RAMP_UP: rup_reg <= dpsm_merge(rup_reg, wr_d, wr_be);
                `DPSM_A_RAMP_LO: rlo_reg <= dpsm_merge(rlo_reg, wr_d, wr_be);
                `DPSM_A_RAMP_RSTEP: rrs_reg <= dpsm_merge(rrs_reg, wr_d, wr_be);
                `DPSM_A_RAMP_FSTEP: rfs_reg <= dpsm_merge(rfs_reg, wr_d, wr_be);
                `DPSM_A_RAMP_RATE: rrate_reg <= dpsm_merge(rrate_reg, wr_d, wr_be);
                `DPSM_A_OSK: osk_reg <= dpsm_merge(osk_reg, wr_d, wr_be);
                `DPSM_A_RAM_ADDR: ram_waddr_reg <= avs_writedata_i[RAM_AW-1:0];
                `DPSM_A_RAM_DATA: ram_waddr_reg <= ram_waddr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
                default: begin
                    // profile banks, eight words each; others ignored
                    if (avs_address_i[7:5] == 3'h2) begin
                        prof_ftw_reg[avs_address_i[4:2]] <= avs_writedata_i;
                    end else if (avs_address_i[7:5] == 3'h3) begin
                        prof_pa_reg[avs_address_i[4:2]] <= avs_writedata_i;
                    end else if (avs_address_i[7:5] == 3'h4) begin
                        rprof_reg[avs_address_i[4:2]] <= avs_writedata_i;
                    end
                end
                endcase
            end
        end
    end

    // one wait state on reads so read data come from a flop
    assign avs_waitrequest_o = avs_read_i && !rd_pend_reg;
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_reg <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            rd_pend_reg <= avs_read_i && !rd_pend_reg;
            case (avs_address_i)
            `DPSM_A_CTRL: avs_readdata_o <= ctrl_reg;
            `DPSM_A_FTW: avs_readdata_o <= ftw_reg;
            `DPSM_A_POW_ASF: avs_readdata_o <= pow_asf_reg;
            `DPSM_A_RAMP_UP: avs_readdata_o <= rup_reg;
            `DPSM_A_RAMP_LO: avs_readdata_o <= rlo_reg;
            `DPSM_A_RAMP_RSTEP: avs_readdata_o <= rrs_reg;
            `DPSM_A_RAMP_FSTEP: avs_readdata_o <= rfs_reg;
            `DPSM_A_RAMP_RATE: avs_readdata_o <= rrate_reg;
            `DPSM_A_OSK: avs_readdata_o <= osk_reg;
            `DPSM_A_STATUS: avs_readdata_o <= {26'h0, ram_active_reg, ramp_limit_flag_o,
                                               act_prof_reg, osk_en};
            `DPSM_A_OUT_FREQ: avs_readdata_o <= freq_o;
            default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // profile select applied on the update tick; the change flag lasts
    // until the next tick so the ram start sees it with the new profile
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            act_prof_reg <= 3'h0;
            prof_chg_reg <= 1'b0;
        end else if (upd_tick) begin
            prof_chg_reg <= (prof_s2_reg != act_prof_reg);
            act_prof_reg <= prof_s2_reg;
        end
    end

    // ram playback: start/end addresses and rate from the active ram profile
    wire [31:0] rprof = rprof_reg[act_prof_reg];
    wire [1:0] ram_dest = rprof[1:0];
    wire [RAM_AW-1:0] rp_start = rprof[2 +: RAM_AW];
    wire [RAM_AW-1:0] rp_end = rprof[12 +: RAM_AW];
    wire [9:0] rp_rate = rprof[22 +: 10];
    reg [RAM_AW-1:0] ram_raddr_reg;
    reg [9:0] ram_timer_reg;
    wire [31:0] ram_q;
    reg [31:0] ram_sample_reg;
    wire ram_en = ctrl_reg[`DPSM_C_RAM_EN];
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ram_active_reg <= 1'b0;
            ram_raddr_reg <= {RAM_AW{1'b0}};
            ram_timer_reg <= 10'h000;
            ram_sample_reg <= 32'h0000_0000;
        end else if (!ram_en) begin
            ram_active_reg <= 1'b0;
        end else if (upd_tick && (ctrl_reg[`DPSM_C_UPDATE] || prof_chg_reg)) begin
            ram_active_reg <= 1'b1;
            ram_raddr_reg <= rp_start;
            ram_timer_reg <= rp_rate;
        end else if (ram_active_reg && upd_tick) begin
            if (ram_timer_reg != 10'h000) begin
                ram_timer_reg <= ram_timer_reg - 10'h001;
            end else begin
                // timer expiry delivers one sample and advances the pointer
                ram_timer_reg <= rp_rate;
                ram_sample_reg <= ram_q;
                ram_raddr_reg <= (ram_raddr_reg == rp_end) ? rp_start
                                 : ram_raddr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
            end
        end
    end

    // waveform memory, written by software, read by playback
    dpsm_wave_ram #(.AW(RAM_AW), .DW(`DPSM_RAM_DW)) u_ram (
        .ref_clk_i(ref_clk_i),
        .we_i(ram_we),
        .waddr_i(ram_waddr_reg),
        .wdata_i(avs_writedata_i),
        .raddr_i(ram_raddr_reg),
        .rdata_o(ram_q)
    );

    // ramp generator, steps on update ticks
    wire [31:0] ramp_acc;
    wire ramp_lim;
    wire ramp_en = ctrl_reg[`DPSM_C_RAMP_EN];
    dpsm_ramp_gen u_ramp (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .enable_i(ramp_en),
        .tick_i(upd_tick),
        .dir_up_i(dir_s2_reg),
        .hold_i(hold_s2_reg),
        .upper_i(rup_reg),
        .lower_i(rlo_reg),
        .rise_step_i(rrs_reg),
        .fall_step_i(rfs_reg),
        .rise_rate_i(rrate_reg[15:0]),
        .fall_rate_i(rrate_reg[31:16]),
        .acc_o(ramp_acc),
        .at_limit_o(ramp_lim)
    );
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ramp_limit_flag_o <= 1'b0;
        end else begin
            ramp_limit_flag_o <= ramp_en && ramp_lim;
        end
    end

    // parallel port latch, gated; clear or hold when gate false
    reg [15:0] pdat_reg;
    reg [1:0] pdst_reg;
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pdat_reg <= 16'h0000;
            pdst_reg <= 2'h0;
        end else if (pdc_rise) begin
            if (gate_s2_reg) begin
                pdat_reg <= pd_s2_reg[17:2];
                pdst_reg <= pd_s2_reg[1:0];
            end else if (!ctrl_reg[`DPSM_C_HOLD_LAST]) begin
                pdat_reg <= 16'h0000;
            end
        end
    end

    // amplitude keying ramp up toward the scale factor; zero while keying is off
    reg [13:0] osk_amp_reg;
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osk_amp_reg <= 14'h0000;
        end else if (!osk_en) begin
            osk_amp_reg <= 14'h0000;
        end else if (upd_tick) begin
            // osk_reg[13:0] target, [29:16] step; saturate at target
            if (osk_amp_reg < osk_reg[13:0]) begin
                osk_amp_reg <= (osk_reg[13:0] - osk_amp_reg > osk_reg[29:16])
                               ? osk_amp_reg + osk_reg[29:16] : osk_reg[13:0];
            end else begin
                osk_amp_reg <= osk_reg[13:0];
            end
        end
    end

    // source selection with fixed priority
    wire [31:0] prof_pa = prof_pa_reg[act_prof_reg];
    wire [3:0] fm_gain = ctrl_reg[`DPSM_C_FMGAIN_LSB +: 4];
    wire [1:0] ramp_dest = ctrl_reg[`DPSM_C_RDEST_LSB +: 2];
    wire port_en = ctrl_reg[`DPSM_C_PORT_EN];
    wire [46:0] fm_off = {31'h0, pdat_reg} << fm_gain;
    reg [31:0] freq_next;
    reg [15:0] phase_next;
    reg [13:0] amp_next;
    always @* begin
        freq_next = prof_ftw_reg[act_prof_reg];
        phase_next = prof_pa[31:16];
        amp_next = prof_pa[13:0];
        // lowest priority first, later assignments win
        if (port_en) begin
            case (pdst_reg)
            `DPSM_DEST_AMP: amp_next = pdat_reg[15:2];
            `DPSM_DEST_PHASE: phase_next = pdat_reg;
            `DPSM_DEST_FREQ: freq_next = ftw_reg + fm_off[31:0];
            default: begin
                amp_next = {pdat_reg[15:8], pow_asf_reg[5:0]};
                phase_next = {pdat_reg[7:0], pow_asf_reg[23:16]};
            end
            endcase
        end
        if (ramp_en) begin
            case (ramp_dest)
            `DPSM_RDEST_FREQ: freq_next = ramp_acc;
            `DPSM_RDEST_PHASE: phase_next = ramp_acc[31:16];
            default: amp_next = ramp_acc[31:18];
            endcase
        end
        if (ram_active_reg) begin
            case (ram_dest)
            `DPSM_RDEST_FREQ: freq_next = ram_sample_reg;
            `DPSM_RDEST_PHASE: phase_next = ram_sample_reg[31:16];
            `DPSM_RDEST_AMP: amp_next = ram_sample_reg[31:18];
            default: begin
                phase_next = ram_sample_reg[31:16];
                amp_next = ram_sample_reg[15:2];
            end
            endcase
        end
        if (osk_en) begin
            amp_next = osk_amp_reg;
        end
    end

    // outputs registered on the update tick
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            freq_o <= 32'h0000_0000;
            phase_o <= 16'h0000;
            amp_o <= 14'h0000;
        end else if (upd_tick) begin
            freq_o <= freq_next;
            phase_o <= phase_next;
            amp_o <= amp_next;
        end
    end
endmodule

//--- logic/dpsm_wave_ram.v
// 1024 x 32 waveform memory with registered read data
`timescale 1ns/1ns
module dpsm_wave_ram #(
    parameter AW = 10,
    parameter DW = 32
) (
    input wire ref_clk_i,
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [DW-1:0] wdata_i,
    input wire [AW-1:0] raddr_i,
    output reg [DW-1:0] rdata_o
);
    // storage array, contents undefined at power up
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // one write port and one registered read port
    always @(posedge ref_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

//--- verification/dpsm_pin_host.sv
// far-side host model driving the profile and parallel port pins
`timescale 1ns/1ns
module dpsm_pin_host (
    input wire clk_i,
    input wire pclk_i,
    input wire [17:0] word_i,
    input wire gate_i,
    input wire [2:0] prof_i,
    output reg [17:0] port_o,
    output reg gate_o,
    output reg [2:0] prof_o
);
    reg pclk_q;
    initial {port_o, gate_o, prof_o, pclk_q} = 23'h0;
    // words launch just after a capture edge so they sit still for a whole port period
    always @(posedge clk_i) begin
        pclk_q <= pclk_i;
        prof_o <= prof_i;
        if (pclk_i && !pclk_q) begin
            gate_o <= gate_i;
            // a released port inverts its word on every port clock, so every other period it shows its last word again
            port_o <= gate_i ? word_i : ~port_o;
        end
    end
endmodule

//--- verification/dpsm_source_mux_monitor.sv
// port checker for the parameter source multiplexer
`timescale 1ns/1ns
module dpsm_mux_monitor (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire avs_waitrequest_o,
    input wire port_data_clock_o,
    input wire [31:0] freq_o,
    input wire [15:0] phase_o,
    input wire [13:0] amp_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // results move only on the quarter-rate update tick, so a change is followed by three still cycles
    a_freq_tick: assert property (!$stable(freq_o) |=> $stable(freq_o)[*3])
        else $error("freq moved between update ticks");
    a_phase_tick: assert property (!$stable(phase_o) |=> $stable(phase_o)[*3])
        else $error("phase moved between update ticks");
    a_amp_tick: assert property (!$stable(amp_o) |=> $stable(amp_o)[*3])
        else $error("amp moved between update ticks");
    // port clock is a square wave at a quarter of the clock rate
    a_pclk_high: assert property ($rose(port_data_clock_o) |=> port_data_clock_o ##1 !port_data_clock_o)
        else $error("port clock high phase wrong");
    a_pclk_low: assert property ($fell(port_data_clock_o) |=> !port_data_clock_o ##1 port_data_clock_o)
        else $error("port clock low phase wrong");
    a_pclk_period: assert property ($rose(port_data_clock_o) |-> ##4 $rose(port_data_clock_o))
        else $error("port clock period wrong");
    // reads stall exactly one cycle, writes never stall
    a_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait not one cycle");
    a_write_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
        else $error("write stalled");
    c_freq: cover property (!$stable(freq_o));
    c_phase: cover property (!$stable(phase_o));
    c_amp: cover property (!$stable(amp_o));
endmodule
bind dpsm_source_mux dpsm_mux_monitor i_dpsm_mux_monitor (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .port_data_clock_o(port_data_clock_o), .freq_o(freq_o), .phase_o(phase_o), .amp_o(amp_o));

//--- verification/dpsm_source_mux_tb.sv
// self-checking bench for the parameter source multiplexer
`timescale 1ns/1ns
`include "dpsm_consts.vh"
module dpsm_source_mux_tb;
    reg clk = 0, nrst = 0, rd = 0, wr = 0, h_gate = 0, h_dir = 1, h_hold = 0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0, frequency_tuning_word, pa, d, v;
    reg [17:0] h_word = 18'h0;
    reg [2:0] h_prof = 3'h0;
    reg [61:0] e;
    wire [31:0] rdat, freq;
    wire [15:0] ph;
    wire [13:0] amp;
    wire [17:0] pword;
    wire [2:0] prof;
    wire wt, pclk, gate, lim;
    integer n_mismatch = 0, n_tests = 0, seed = 22, i, k;
    always #20 clk = ~clk;
    dpsm_pin_host i_dpsm_pin_host (.clk_i(clk), .pclk_i(pclk), .word_i(h_word), .gate_i(h_gate),
        .prof_i(h_prof), .port_o(pword), .gate_o(gate), .prof_o(prof));
    dpsm_source_mux i_dpsm_source_mux (.ref_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .profile_i(prof),
        .ramp_direction_pin_i(h_dir), .ramp_hold_pin_i(h_hold), .port_data_i(pword),
        .port_data_gate_i(gate), .port_data_clock_o(pclk), .ramp_limit_flag_o(lim),
        .freq_o(freq), .phase_o(ph), .amp_o(amp));
    task end_sim;
        begin
            if (n_mismatch == 0 && n_tests > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [8*5-1:0] nm, input [31:0] ex, input [31:0] sn);
        begin
            n_tests = n_tests + 1;
            if (ex !== sn) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s expected %h seen %h", nm, ex, sn);
            end
        end
    endtask
    // one bus cycle; held until waitrequest is seen low into a rising edge
    task bus(input w, input [7:0] a, input [31:0] dat);
        begin
            @(posedge clk);
            adr <= a;
            wdat <= dat;
            wr <= w;
            rd <= !w;
            @(negedge clk);
            while (wt) @(negedge clk);
            v = rdat;
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    // waits a bounded time for the results to settle, then compares all three
    task settle(input [61:0] x);
        begin
            for (k = 0; k < 40 && {freq, ph, amp} !== x; k = k + 1) @(negedge clk);
            chk("freq", x[61:30], freq);
            chk("phase", {16'h0, x[29:14]}, {16'h0, ph});
            chk("amp", {18'h0, x[13:0]}, {18'h0, amp});
        end
    endtask
    // unmodulated words come from the registers, the port word lands per destination code
    function [61:0] port_exp(input [1:0] dst, input [15:0] dw, input [3:0] gn);
        begin
            port_exp = {frequency_tuning_word, pa[31:16], pa[13:0]};
            case (dst)
                2'h0: port_exp[13:0] = dw[15:2];
                2'h1: port_exp[29:14] = dw;
                2'h2: port_exp[61:30] = frequency_tuning_word + ({16'h0, dw} << gn);
                default: port_exp[29:0] = {dw[7:0], pa[23:16], dw[15:8], pa[5:0]};
            endcase
        end
    endfunction
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 8; i = i + 1) begin
            frequency_tuning_word = $random(seed);
            pa = $random(seed);
            bus(1'b1, 8'h40 + {3'h0, i[2:0], 2'h0}, frequency_tuning_word);
            bus(1'b1, 8'h60 + {3'h0, i[2:0], 2'h0}, pa);
            h_prof <= i[2:0];
            settle({frequency_tuning_word, pa[31:16], pa[13:0]});
        end
        bus(1'b1, `DPSM_A_FTW, frequency_tuning_word);
        bus(1'b1, `DPSM_A_POW_ASF, pa);
        bus(1'b0, `DPSM_A_FTW, 32'h0);
        chk("rdata", frequency_tuning_word, v);
        bus(1'b0, 8'hFC, 32'h0);
        chk("rdata", 32'h0, v);
        h_gate <= 1'b1;
        // every destination code with every gain, all-ones word at top gain
        for (i = 0; i < 64; i = i + 1) begin
            d = (i[3:0] == 4'hF) ? 32'hFFFF : $random(seed);
            bus(1'b1, `DPSM_A_CTRL, {19'h0, 1'b1, i[3:0], 8'h04});
            h_word <= {d[15:0], i[5:4]};
            e = port_exp(i[5:4], d[15:0], i[3:0]);
            settle(e);
        end
        // gate low: host now toggles the port, last word must be kept
        h_gate <= 1'b0;
        repeat (40) @(posedge clk);
        settle(e);
        // ramp up to the limit, freeze it, fall; then keying, then ram
        e = {frequency_tuning_word, pa[31:16], pa[13:0]};
        bus(1'b1, `DPSM_A_RAMP_UP, 32'h500);
        bus(1'b1, `DPSM_A_RAMP_RSTEP, 32'h100);
        bus(1'b1, `DPSM_A_RAMP_FSTEP, 32'h100);
        bus(1'b1, `DPSM_A_CTRL, 32'h2);
        settle({32'h500, e[29:0]});
        chk("lim", 32'h1, {31'h0, lim});
        {h_hold, h_dir} <= 2'h2;
        repeat (40) @(posedge clk);
        settle({32'h500, e[29:0]});
        h_hold <= 1'b0;
        settle({32'h0, e[29:0]});
        bus(1'b1, `DPSM_A_OSK, 32'h0400_1234);
        bus(1'b1, `DPSM_A_CTRL, 32'h4A);
        settle({e[61:14], 14'h1234});
        d = $random(seed);
        bus(1'b1, `DPSM_A_RAM_DATA, d);
        bus(1'b1, `DPSM_A_CTRL, 32'h11);
        settle({d, e[29:0]});
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        end_sim;
    end
endmodule
